// ---- efi_fifo.sv ----
// Purpose: Small synchronous FIFO in the transmit symbol path.
// Assumes: Push and pop in one clock domain, DEPTH a power of two.
// Notes: Full and empty are registered so ready and valid come from flops.
`timescale 1ns/10ps
module efi_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Fill side and drain side
    efi_stream_if.snk push,
    efi_stream_if.src pop
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic [PW:0] next_count;
    logic full_q;
    logic empty_q;
    logic do_push;
    logic do_pop;

    // Handshakes; a stalled drain side lets the FIFO fill and push back
    assign do_push = push.valid && !full_q;
    assign do_pop = pop.ready && !empty_q;
    assign push.ready = !full_q;
    assign pop.valid = !empty_q;
    assign pop.data = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (do_push && !do_pop) begin
            next_count = count + 1'b1;
        end else if (do_pop && !do_push) begin
            next_count = count - 1'b1;
        end
    end

    // Storage; no reset needed on the data words
    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            mem[wr_ptr] <= push.data;
        end
    end

    // Pointers and flags
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= next_count;
            full_q <= (next_count == DEPTH_C);
            empty_q <= (next_count == '0);
        end
    end

    property p_fifo_full;
        @(posedge ref_clk) disable iff (srst)
        (count == DEPTH_C) |-> !push.ready;
    endproperty
    a_fifo_full: assert property (p_fifo_full) else $error("FIFO accepts while full");

    property p_fifo_empty;
        @(posedge ref_clk) disable iff (srst)
        (count == '0) |-> !pop.valid;
    endproperty
    a_fifo_empty: assert property (p_fifo_empty) else $error("FIFO offers data while empty");
endmodule

// ---- efi_frame_gen.sv ----
// Purpose: Frame generator and line sink facing the inserter's stream ports.
// Assumes: Sixteen-symbol frames, alignment word in the first ten symbols.
// Notes: Frames only start at a frame boundary, so a run always ends on a whole frame.
`timescale 1ns/10ps
module efi_frame_gen
    import efi_pkg::*;
#(
    parameter int FRAME_LEN = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Bench controls
    input wire logic run,
    input wire logic stall,
    output logic busy,
    // Generator side
    output logic in_valid = 1'b0,
    input wire logic in_ready,
    output logic in_bit = 1'b0,
    output logic in_fas = 1'b0,
    output logic in_fas_start = 1'b0,
    // Line side
    output logic out_ready = 1'b0
);
    int pos = 0;

    assign busy = in_valid || (pos != 0);

    // Symbol source; idle lines show inverted levels so stale data never passes for valid
    always @(posedge ref_clk) begin
        if (srst) begin
            in_valid <= 1'b0;
            pos <= 0;
        end else if (!in_valid || in_ready) begin
            if (run || pos != 0) begin
                in_valid <= 1'b1;
                in_bit <= 1'($urandom);
                in_fas <= (pos < EFI_FAS_LEN);
                in_fas_start <= (pos == 0);
                pos <= (pos + 1) % FRAME_LEN;
            end else begin
                in_valid <= 1'b0;
                in_bit <= ~in_bit;
                in_fas <= ~in_fas;
                in_fas_start <= ~in_fas_start;
            end
        end
    end

    // Line side stalls at random, and fully on request so the buffer fills
    always @(posedge ref_clk) begin
        out_ready <= !srst && !stall && ($urandom_range(3) != 0);
    end
endmodule

// ---- efi_inserter.sv ----
// Purpose: E3 transmit framing error inserter with Avalon-MM control registers.
// Assumes: One transmit symbol per beat, alignment bits flagged, first one marked.
// Notes: Corrupted symbols pass through a four-word FIFO to the line side.
//
// Summary of operation
// - Kinds 00/01: one bit or word, one frame
// - Kinds 10/11: bit or word, four frames
// - No corruption while insertion enable is zero
// - Software trigger rising edge inserts one error
// - Repeated toggles before opportunity give one error
// - Source select picks software or external trigger
// - Switching source with trigger high may insert
// - Alignment word spans up to ten bits
`timescale 1ns/10ps
module efi_inserter
    import efi_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Avalon-MM slave
    input wire logic [EFI_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // External manual insert request, asynchronous
    input wire logic ext_err_insert_input,
    // Transmit symbols in from the frame generator
    input wire logic in_valid,
    output logic in_ready,
    input wire logic in_bit,
    input wire logic in_fas,
    input wire logic in_fas_start,
    // Transmit symbols out to the line
    output logic out_valid,
    input wire logic out_ready,
    output logic out_bit,
    output logic out_fas,
    output logic out_fas_start
);
    typedef enum logic [0:0] {
        EFI_BUS_IDLE,
        EFI_BUS_ACK
    } efi_bus_st_t;

    efi_bus_st_t bus_st;
    logic [EFI_CTRL_W-1:0] ctrl;
    logic src_sel;
    logic sw_trig;
    logic en;
    efi_kind_t kind;
    logic wr_ctrl;
    logic [31:0] rd_mux;

    logic ext_meta;
    logic ext_sync;
    logic trig_level;
    logic trig_q;
    logic req;
    logic pending;

    logic fire;
    logic opp;
    logic take;
    logic [2:0] frames_left;
    logic burst_more;
    logic cur_corrupt;
    logic word_q;
    logic [3:0] fas_cnt;
    logic flip;
    logic [7:0] err_count;

    efi_stream_if #(.W(EFI_SYM_W)) fill_if ();
    efi_stream_if #(.W(EFI_SYM_W)) drain_if ();

    // Field views of the control register
    assign src_sel = ctrl[EFI_SRC_BIT];
    assign sw_trig = ctrl[EFI_SWTRIG_BIT];
    assign en = ctrl[EFI_EN_BIT];
    assign kind = efi_kind_t'(ctrl[EFI_KIND_LSB +: 2]);

    // Bus handshake: one wait cycle, then the transfer completes
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bus_st <= EFI_BUS_IDLE;
            waitrequest <= 1'b1;
        end else begin
            unique case (bus_st)
                EFI_BUS_IDLE: begin
                    if (read || write) begin
                        waitrequest <= 1'b0;
                        bus_st <= EFI_BUS_ACK;
                    end
                end
                EFI_BUS_ACK: begin
                    waitrequest <= 1'b1;
                    bus_st <= EFI_BUS_IDLE;
                end
            endcase
        end
    end

    // Read mux; unmapped addresses read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (address == EFI_CTRL_ADDR) begin
            rd_mux[EFI_CTRL_W-1:0] = ctrl;
        end else if (address == EFI_STAT_ADDR) begin
            rd_mux[EFI_ST_PEND_BIT] = pending;
            rd_mux[EFI_ST_LEFT_LSB +: 3] = frames_left;
            rd_mux[EFI_ST_ACT_BIT] = cur_corrupt;
            rd_mux[EFI_ST_CNT_LSB +: 8] = err_count;
        end
    end

    // Read data is loaded with the wait release and stands through that cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            readdata <= 32'h0000_0000;
        end else if (bus_st == EFI_BUS_IDLE && read) begin
            readdata <= rd_mux;
        end
    end

    // Writes land at the edge where waitrequest is seen low
    assign wr_ctrl = (bus_st == EFI_BUS_ACK) && write && byteenable[0]
                     && (address == EFI_CTRL_ADDR);

    // Control register; reserved bits are not stored and read zero
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl <= EFI_CTRL_RST[EFI_CTRL_W-1:0];
        end else if (wr_ctrl) begin
            ctrl <= writedata[EFI_CTRL_W-1:0];
        end
    end

    // External request crosses in through two flops before any use
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
        end else begin
            ext_meta <= ext_err_insert_input;
            ext_sync <= ext_meta;
        end
    end

    // a source swap may look like an edge; that is accepted behaviour
    assign trig_level = src_sel ? ext_sync : sw_trig;

    // Previous trigger level for edge detection
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= trig_level;
        end
    end

    // a held trigger gives no further edge
    assign req = trig_level && !trig_q;

    // Symbol handshake and insertion opportunity at the alignment word start
    assign fire = in_valid && in_ready;
    assign opp = fire && in_fas && in_fas_start;
    assign burst_more = (frames_left != 3'h0);
    // A request waits until any running burst has finished
    assign take = opp && pending && en && !burst_more;

    // one pending flag, so extra edges merge into one error
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pending <= 1'b0;
        end else if (req && en) begin
            pending <= 1'b1; // A new edge beats the clear in the same cycle
        end else if (take || !en) begin
            pending <= 1'b0;
        end
    end

    // kind bit 0 latched as word error
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            frames_left <= 3'h0;
            word_q <= 1'b0;
        end else if (!en) begin
            frames_left <= 3'h0;
        end else if (take) begin
            frames_left <= kind[1] ? EFI_BURST_MORE : 3'h0;
            word_q <= kind[0];
        end else if (opp && burst_more) begin
            frames_left <= frames_left - 1'b1;
        end
    end

    // Current frame being corrupted; cleared by the first accepted symbol after the alignment word
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cur_corrupt <= 1'b0;
        end else if (opp) begin
            cur_corrupt <= en && (take || burst_more);
        end else if (fire && !in_fas) begin
            cur_corrupt <= 1'b0;
        end
    end

    // alignment bit count, capped at ten
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            fas_cnt <= 4'h0;
        end else if (opp) begin
            fas_cnt <= 4'h1;
        end else if (fire && in_fas && fas_cnt < 4'(EFI_FAS_LEN)) begin
            fas_cnt <= fas_cnt + 1'b1;
        end
    end

    // invert first bit, or every alignment bit for a word error
    always_comb begin
        flip = 1'b0;
        if (fire && in_fas && en) begin
            if (in_fas_start) begin
                flip = take || burst_more;
            end else begin
                flip = cur_corrupt && word_q && (fas_cnt < 4'(EFI_FAS_LEN));
            end
        end
    end

    // Frames corrupted so far, wraps, visible in status
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            err_count <= 8'h00;
        end else if (opp && en && (take || burst_more)) begin
            err_count <= err_count + 1'b1;
        end
    end

    // Symbols into the FIFO; back-pressure reaches the frame generator
    assign fill_if.valid = in_valid;
    assign fill_if.data[EFI_SYM_BIT] = in_bit ^ flip;
    assign fill_if.data[EFI_SYM_FAS] = in_fas;
    assign fill_if.data[EFI_SYM_START] = in_fas_start;
    assign in_ready = fill_if.ready;

    efi_fifo #(
        .WIDTH(EFI_SYM_W),
        .DEPTH(EFI_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .srst(srst),
        .push(fill_if.snk),
        .pop(drain_if.src)
    );

    // Line side comes straight from FIFO flops
    assign drain_if.ready = out_ready;
    assign out_valid = drain_if.valid;
    assign out_bit = drain_if.data[EFI_SYM_BIT];
    assign out_fas = drain_if.data[EFI_SYM_FAS];
    assign out_fas_start = drain_if.data[EFI_SYM_START];

    // Checks

    sequence s_bus_req;
        (bus_st == EFI_BUS_IDLE) && (read || write);
    endsequence

    sequence s_bus_done;
        !waitrequest ##1 waitrequest;
    endsequence

    property p_bus_answer;
        @(posedge ref_clk) disable iff (srst)
        s_bus_req |=> s_bus_done;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("Bus answer not one cycle");

    property p_single_kind;
        @(posedge ref_clk) disable iff (srst)
        (flip && !in_fas_start) |-> (word_q && cur_corrupt);
    endproperty
    a_single_kind: assert property (p_single_kind) else $error("Bit error touched more bits");

    sequence s_burst_take;
        take && kind[1];
    endsequence

    property p_burst_len;
        @(posedge ref_clk) disable iff (srst)
        s_burst_take |=> (frames_left == 3'h3 || !en);
    endproperty
    a_burst_len: assert property (p_burst_len) else $error("Four-frame burst not armed");

    property p_enable_gate;
        @(posedge ref_clk) disable iff (srst)
        !en |-> !flip ##1 (!pending && frames_left == 3'h0);
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("Corruption while disabled");

    property p_sw_edge;
        @(posedge ref_clk) disable iff (srst)
        (!src_sel && $stable(src_sel) && $rose(sw_trig) && en) |-> req ##1 pending;
    endproperty
    a_sw_edge: assert property (p_sw_edge) else $error("Software edge not taken");

    property p_merge;
        @(posedge ref_clk) disable iff (srst)
        (take && !req) |=> !pending;
    endproperty
    a_merge: assert property (p_merge) else $error("Request survived insertion");

    property p_src_mask;
        @(posedge ref_clk) disable iff (srst)
        (src_sel && $stable(src_sel) && $stable(ext_sync)) |-> !req;
    endproperty
    a_src_mask: assert property (p_src_mask) else $error("Unselected source triggered");

    property p_ext_edge;
        @(posedge ref_clk) disable iff (srst)
        (src_sel && $stable(src_sel) && $rose(ext_sync)) |-> req;
    endproperty
    a_ext_edge: assert property (p_ext_edge) else $error("External edge missed");

    property p_fas_cap;
        @(posedge ref_clk) disable iff (srst)
        fas_cnt <= 4'(EFI_FAS_LEN);
    endproperty
    a_fas_cap: assert property (p_fas_cap) else $error("Alignment count above ten");

    property p_flip_fas;
        @(posedge ref_clk) disable iff (srst)
        flip |-> (in_fas && fire && fill_if.data[EFI_SYM_BIT] != in_bit);
    endproperty
    a_flip_fas: assert property (p_flip_fas) else $error("Inverted a non-alignment bit");
endmodule

// ---- efi_pkg.sv ----
// Purpose: Shared constants for the E3 transmit framing error inserter.
// Assumes: Avalon-MM slave with 32-bit data and byte addresses.
// Notes: Register indices are kept as printed; byte address is four times the index.
package efi_pkg;
    // Register indices and byte addresses
    localparam int EFI_ADDR_W = 12;
    localparam logic [EFI_ADDR_W-1:0] EFI_CTRL_IDX = 12'h11a;
    localparam logic [EFI_ADDR_W-1:0] EFI_STAT_IDX = 12'h11b;
    localparam logic [EFI_ADDR_W-1:0] EFI_CTRL_ADDR = 12'h468;
    localparam logic [EFI_ADDR_W-1:0] EFI_STAT_ADDR = 12'h46c;

    // Control register fields
    localparam int EFI_SRC_BIT = 0;
    localparam int EFI_SWTRIG_BIT = 1;
    localparam int EFI_EN_BIT = 2;
    localparam int EFI_KIND_LSB = 3;
    localparam int EFI_CTRL_W = 5;
    localparam logic [15:0] EFI_CTRL_RST = 16'h0000;

    // Status register fields
    localparam int EFI_ST_PEND_BIT = 0;
    localparam int EFI_ST_LEFT_LSB = 1;
    localparam int EFI_ST_ACT_BIT = 4;
    localparam int EFI_ST_CNT_LSB = 8;

    // Frame alignment word and burst length
    localparam int EFI_FAS_LEN = 10;
    localparam logic [2:0] EFI_BURST_MORE = 3'h3;

    // Transmit symbol layout
    localparam int EFI_SYM_BIT = 0;
    localparam int EFI_SYM_FAS = 1;
    localparam int EFI_SYM_START = 2;
    localparam int EFI_SYM_W = 3;
    localparam int EFI_FIFO_DEPTH = 4;

    // Error kinds
    typedef enum logic [1:0] {
        EFI_BIT_ONE = 2'h0,
        EFI_WORD_ONE = 2'h1,
        EFI_BIT_FOUR = 2'h2,
        EFI_WORD_FOUR = 2'h3
    } efi_kind_t;
endpackage

// ---- efi_stream_if.sv ----
// Purpose: Valid/ready symbol stream between the inserter and its FIFO.
// Assumes: Single clock domain.
// Notes: Producer drives valid and data, consumer drives ready.
`timescale 1ns/10ps
interface efi_stream_if #(parameter int W = 3);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ---- testbench.sv ----
// Purpose: Self-checking bench for the E3 transmit framing error inserter.
// Assumes: Registers reached over Avalon-MM, one wait cycle per transfer.
// Notes: A queue model predicts every output symbol from the accepted inputs.
`timescale 1ns/10ps
module testbench;
    import efi_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [EFI_ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'h0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic ext_err_insert_input = 1'b0;
    logic in_valid, in_ready, in_bit, in_fas, in_fas_start;
    logic out_valid, out_ready, out_bit, out_fas, out_fas_start;
    logic run = 1'b0;
    logic stall = 1'b0;
    logic busy;
    logic [31:0] rd;
    logic [1:0] mkind = 2'h0;
    logic frame_bad = 1'b0;
    logic [EFI_SYM_W-1:0] exp_q[$];
    int n_errors = 0;
    int samples_checked = 0;
    int corrupt_left = 0;
    int starts_seen = 0;
    int n_bad = 0;

    always #5 ref_clk = ~ref_clk;

    efi_inserter i_efi_inserter(.ref_clk(ref_clk), .srst(srst), .address(address),
        .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .ext_err_insert_input(ext_err_insert_input), .in_valid(in_valid),
        .in_ready(in_ready), .in_bit(in_bit), .in_fas(in_fas), .in_fas_start(in_fas_start),
        .out_valid(out_valid), .out_ready(out_ready), .out_bit(out_bit),
        .out_fas(out_fas), .out_fas_start(out_fas_start));

    efi_frame_gen i_efi_frame_gen(.ref_clk(ref_clk), .srst(srst), .run(run), .stall(stall),
        .busy(busy), .in_valid(in_valid), .in_ready(in_ready), .in_bit(in_bit),
        .in_fas(in_fas), .in_fas_start(in_fas_start), .out_ready(out_ready));

    task conclude;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task report(input logic [31:0] e, input logic [31:0] g);
        n_errors++;
        $display("wrong value at %0t: expected %h got %h", $time, e, g);
    endtask

    task cmp_sym(input logic [EFI_SYM_W-1:0] e, input logic [EFI_SYM_W-1:0] g);
        samples_checked++;
        if (g !== e) report(32'(e), 32'(g));
    endtask

    task cmp_reg(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) report(e, g);
    endtask

    task cmp_bit(input logic e, input logic g);
        samples_checked++;
        if (g !== e) report(32'(e), 32'(g));
    endtask

    task timeout;
        n_errors++;
        conclude();
    endtask

    task cycles(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // One bus transfer, held until waitrequest is sampled low
    task bus(input logic wr, input logic [EFI_ADDR_W-1:0] a, input logic [31:0] d,
             input logic [3:0] be);
        int i;
        @(posedge ref_clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= wr;
        read <= !wr;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (waitrequest !== 1'b0 && i < 100);
        if (i >= 100) timeout();
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task ctrl(input logic src, input logic trig, input logic en, input logic [1:0] kind);
        bus(1'b1, EFI_CTRL_ADDR, {27'h0, kind, en, trig, src}, 4'h1);
    endtask

    task check_reg(input logic [EFI_ADDR_W-1:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        cmp_reg(e, rd);
    endtask

    task pulse;
        ext_err_insert_input <= 1'b1;
        cycles(4);
        ext_err_insert_input <= 1'b0;
        cycles(8);
    endtask

    // Stop the source and wait until every predicted symbol has left the line side
    task drain;
        int i;
        run <= 1'b0;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while ((busy || out_valid || exp_q.size() != 0) && i < 2000);
        if (i >= 2000) timeout();
    endtask

    // Send whole frames; the model corrupts the first 'bad' of them
    task frames(input logic [1:0] kind, input int bad, input int nfr);
        int i;
        int t;
        cycles(3);
        mkind = kind;
        corrupt_left = bad;
        t = starts_seen + nfr;
        run <= 1'b1;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (starts_seen < t && i < 2000);
        if (i >= 2000) timeout();
        drain();
    endtask

    // Reference model: predict each accepted symbol, compare each delivered one
    always @(posedge ref_clk) begin : model
        logic [EFI_SYM_W-1:0] s;
        if (!srst && in_valid && in_ready) begin
            s = {in_fas_start, in_fas, in_bit};
            if (in_fas_start) begin
                frame_bad = (corrupt_left > 0);
                if (frame_bad) begin
                    corrupt_left--;
                    n_bad++;
                end
                starts_seen++;
            end
            if (frame_bad && in_fas && (mkind[0] || in_fas_start)) s[EFI_SYM_BIT] = ~s[EFI_SYM_BIT];
            exp_q.push_back(s);
        end
        if (!srst && out_valid && out_ready) begin
            s = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
            cmp_sym(s, {out_fas_start, out_fas, out_bit});
        end
    end

    // Main sequence
    initial begin
        rd = $urandom(86565);
        cycles(3);
        srst <= 1'b0;
        check_reg(EFI_CTRL_ADDR, 32'h0);
        check_reg(12'h400, 32'h0);
        check_reg(EFI_STAT_ADDR, 32'h0);
        // Each kind once; holding the trigger high must then give nothing more
        for (int k = 0; k < 4; k++) begin
            ctrl(1'b0, 1'b0, 1'b1, 2'(k));
            ctrl(1'b0, 1'b1, 1'b1, 2'(k));
            frames(2'(k), (k > 1) ? 4 : 1, 6);
            frames(2'(k), 0, 2);
        end
        // Repeated toggles before one opportunity
        ctrl(1'b0, 1'b0, 1'b1, 2'h1);
        ctrl(1'b0, 1'b1, 1'b1, 2'h1);
        ctrl(1'b0, 1'b0, 1'b1, 2'h1);
        ctrl(1'b0, 1'b1, 1'b1, 2'h1);
        check_reg(EFI_STAT_ADDR, {16'h0, 8'(n_bad), 8'h01});
        frames(2'h1, 1, 3);
        // A trigger edge while disabled is dropped
        ctrl(1'b0, 1'b0, 1'b0, 2'h3);
        ctrl(1'b0, 1'b1, 1'b0, 2'h3);
        frames(2'h3, 0, 5);
        // Masked lane, reserved bits and unmapped writes leave control alone
        bus(1'b1, EFI_CTRL_ADDR, 32'h1f, 4'h0);
        check_reg(EFI_CTRL_ADDR, 32'h1a);
        bus(1'b1, EFI_CTRL_ADDR, 32'hffff_ffe4, 4'hf);
        check_reg(EFI_CTRL_ADDR, 32'h4);
        bus(1'b1, 12'h400, 32'h1f, 4'hf);
        check_reg(EFI_CTRL_ADDR, 32'h4);
        // Source switched only with both triggers low, so no stray request
        ctrl(1'b1, 1'b0, 1'b1, 2'h0);
        pulse();
        frames(2'h0, 1, 3);
        ctrl(1'b1, 1'b1, 1'b1, 2'h0);
        frames(2'h0, 0, 2);
        // Swapping to software while its trigger is high reads as an edge here
        ctrl(1'b0, 1'b1, 1'b1, 2'h0);
        frames(2'h0, 1, 2);
        ctrl(1'b1, 1'b0, 1'b1, 2'h0);
        ctrl(1'b0, 1'b0, 1'b1, 2'h0);
        pulse();
        frames(2'h0, 0, 2);
        // Buffer fills while the line side stalls, then drains
        corrupt_left = 0;
        stall <= 1'b1;
        run <= 1'b1;
        cycles(40);
        cmp_bit(1'b0, in_ready);
        cmp_bit(1'b1, out_valid);
        stall <= 1'b0;
        drain();
        check_reg(EFI_STAT_ADDR, {16'h0, 8'(n_bad), 8'h00});
        conclude();
    end
endmodule
